// ==== core/smc_pkg.sv ====
// constants, mode codes and frame layout for the system mode controller
// assumes a single 200 MHz clock and a decoded 32-bit spi frame
package smc_pkg;

    // operating modes
    typedef enum logic [2:0]
    {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h2,
        MODE_SLEEP = 3'h3,
        MODE_RESTART = 3'h4,
        MODE_FAILSAFE = 3'h5
    } smc_mode_t;

    // clock and timing; least times round up to whole cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_DELAY_TIME_US = 10;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEVMODE_STRAP_FILTER_TIME_NS = 1000;
    localparam int DEVMODE_FILTER_CYC =
        (DEVMODE_STRAP_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHECKSUM_FILTER_TIME_NS = 1000;
    localparam int CHECKSUM_FILTER_CYC =
        (CHECKSUM_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_W = 16;
    localparam logic [RD_W-1:0] RD_LAST = RD_W'(RESET_DELAY_CYC - 1);

    // spi frame layout
    localparam int FRM_RW_BIT = 31;
    localparam int FRM_ADDR_HI = 30;
    localparam int FRM_ADDR_LO = 24;
    localparam int MREQ_HI = 10;
    localparam int MREQ_LO = 8;
    localparam int WDRST_EN_BIT = 11;
    localparam int FEAT_HI = 15;
    localparam int FEAT_LO = 8;

    // register addresses
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_FEATURE = 7'h02;
    localparam logic [6:0] ADDR_WD_REFRESH = 7'h03;
    localparam logic [6:0] ADDR_SPI_STAT = 7'h04;

    // mode request field codes
    localparam logic [2:0] MREQ_NORMAL = 3'h0;
    localparam logic [2:0] MREQ_STOP = 3'h1;
    localparam logic [2:0] MREQ_SLEEP = 3'h2;
    localparam logic [2:0] MREQ_SOFT_RESET = 3'h3;

    // feature enable bit positions and reset value
    localparam int F_HS = 0;
    localparam int F_BD = 1;
    localparam int F_CP = 2;
    localparam int F_CSA = 3;
    localparam int F_CAN = 4;
    localparam int F_CSENSE = 5;
    localparam int F_CWAKE = 6;
    localparam int F_WD = 7;
    localparam logic [7:0] FEAT_RST = 8'h00;

    // fixed checksum recovery frames
    localparam logic [31:0] CHK_ON_FRAME = 32'h67AAAA0E;
    localparam logic [31:0] CHK_OFF_FRAME = 32'hE7AAAAC3;

endpackage

// ==== core/smc_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous levels
// assumes every bit is an independent slow level
`timescale 1ns/100ps
module smc_sync
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic host_reset_line_n,
    // levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            stage1 <= RST_VAL;
            dout <= RST_VAL;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

// ==== core/smc_strap_filter.sv ====
// digital filter for a strap level: output follows after LEN stable samples
// assumes din is already synchronised to clk
`timescale 1ns/100ps
module smc_strap_filter
#(
    parameter int LEN = 200,
    parameter logic INIT_VAL = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic host_reset_line_n,
    // control
    input wire logic load,
    input wire logic loadVal,
    input wire logic enable,
    // level
    input wire logic din,
    output logic q
);

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(LEN - 1);

    logic [CW-1:0] count;

    // any glitch shorter than the filter time restarts the count
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            q <= INIT_VAL;
            count <= '0;
        end
        else if (load)
        begin
            q <= loadVal;
            count <= '0;
        end
        else if (enable && (din != q))
        begin
            if (count == LAST)
            begin
                q <= din;
                count <= '0;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
        else
        begin
            count <= '0;
        end
    end

endmodule

// ==== core/smc_mode_controller.sv ====
// system mode controller: operating modes, per-mode enables and strap latching
// assumes frames come decoded and checksum-checked from an spi slave on clk
`timescale 1ns/100ps
module smc_mode_controller
(
    // clock and reset
    input wire logic clk,
    input wire logic host_reset_line_n,
    // supply and fault status, asynchronous to clk
    input wire logic porFlag,
    input wire logic regAboveReset,
    input wire logic wakeEvent,
    input wire logic wdFault,
    input wire logic regUndervoltage,
    input wire logic thermalShutdown,
    // strap pins
    input wire logic devStrapPin,
    input wire logic firstPwmChecksumStrapPin,
    // decoded spi frames, one-cycle valid
    input wire logic frameValid,
    input wire logic [31:0] frameWord,
    // mode, reset and straps
    output logic [2:0] modeState,
    output logic hostResetLineN,
    output logic devStrapPullup,
    output logic devMode,
    output logic checksumEnable,
    // events and flags
    output logic spiFail,
    output logic wdFailIrq,
    output logic wdLongWindowStart,
    output logic wakeBitsClear,
    // per-mode function enables
    output logic mainRegulatorOn,
    output logic supervisionOn,
    output logic wdRun,
    output logic highSideOn,
    output logic bridgeDriverOn,
    output logic chargePumpOn,
    output logic csaOn,
    output logic canOn,
    output logic canWakeCapable,
    output logic wakeInputsArmed,
    output logic cycSenseOn,
    output logic cycWakeOn
);

    // synchronised inputs; straps idle high through their pull-ups
    logic [7:0] syncIn;
    logic [7:0] syncOut;
    logic porS, regOkS, wakeS, wdFaultS, regUvS, thermalS, devStrapS, chkStrapS;

    assign syncIn = {devStrapPin, firstPwmChecksumStrapPin, thermalShutdown, regUndervoltage,
                     wdFault, wakeEvent, regAboveReset, porFlag};
    assign {devStrapS, chkStrapS, thermalS, regUvS, wdFaultS, wakeS, regOkS, porS} = syncOut;

    smc_sync #(.WIDTH(8), .RST_VAL(8'hC0)) u_sync
    (
        .clk(clk),
        .host_reset_line_n(host_reset_line_n),
        .din(syncIn),
        .dout(syncOut)
    );

    // state
    smc_pkg::smc_mode_t mode;
    smc_pkg::smc_mode_t next_mode;
    logic fromPowerUp;
    logic [smc_pkg::RD_W-1:0] rdCount;
    logic [7:0] feat;
    logic wdRstReenable;
    logic next_auto;
    logic modeEntry;

    // frame decode
    logic isWrite, isCtrl, isFeat, isRefresh, isStatClr, stopOk, accept;
    logic [6:0] addr;
    logic [2:0] mreq;

    assign addr = frameWord[smc_pkg::FRM_ADDR_HI:smc_pkg::FRM_ADDR_LO];
    assign mreq = frameWord[smc_pkg::MREQ_HI:smc_pkg::MREQ_LO];
    assign isWrite = frameValid && frameWord[smc_pkg::FRM_RW_BIT];
    assign isCtrl = isWrite && (addr == smc_pkg::ADDR_MODE_CTRL);
    assign isFeat = isWrite && (addr == smc_pkg::ADDR_FEATURE);
    assign isRefresh = isWrite && (addr == smc_pkg::ADDR_WD_REFRESH);
    assign isStatClr = isWrite && (addr == smc_pkg::ADDR_SPI_STAT);

    // reads and the writes that stop mode still honours
    assign stopOk = !isWrite || isRefresh || isStatClr
        || (isCtrl && ((mreq == smc_pkg::MREQ_NORMAL) || (mreq == smc_pkg::MREQ_SOFT_RESET)));
    assign accept = frameValid && ((mode != smc_pkg::MODE_STOP) || stopOk);

    // derived conditions
    logic inResetPhase, rdDone, resetRise, softReset, wdResets, failure;
    logic devMonitor, chkWindow, devFilt, chkFilt;

    assign inResetPhase = !hostResetLineN
        && ((mode == smc_pkg::MODE_INIT) || (mode == smc_pkg::MODE_RESTART));
    assign rdDone = (rdCount == smc_pkg::RD_LAST);
    assign resetRise = inResetPhase && rdDone;
    assign softReset = accept && isCtrl && (mreq == smc_pkg::MREQ_SOFT_RESET)
        && (mode != smc_pkg::MODE_RESTART);
    // in dev mode a watchdog fault resets only once re-enabled
    assign wdResets = wdFaultS && (!devMode || wdRstReenable);
    assign failure = wdResets || regUvS;
    assign modeEntry = (next_mode != mode) || softReset;
    assign devMonitor = (mode == smc_pkg::MODE_INIT) && fromPowerUp && regOkS && porS
        && hostResetLineN;
    assign chkWindow = (((mode == smc_pkg::MODE_INIT) && fromPowerUp)
        || (mode == smc_pkg::MODE_RESTART)) && regOkS && porS && !hostResetLineN;

    // mode transitions; thermal shutdown outranks everything, but is not checked once in fail-safe
    always_comb
    begin
        next_mode = mode;
        next_auto = 1'b0;
        if (thermalS && (mode != smc_pkg::MODE_FAILSAFE))
        begin
            next_mode = smc_pkg::MODE_FAILSAFE;
            next_auto = 1'b1;
        end
        else if (softReset)
        begin
            next_mode = smc_pkg::MODE_INIT;
        end
        else
        begin
            unique case (mode)
                smc_pkg::MODE_INIT, smc_pkg::MODE_NORMAL:
                begin
                    if (failure && hostResetLineN)
                    begin
                        next_mode = smc_pkg::MODE_RESTART;
                        next_auto = 1'b1;
                    end
                    else if (accept && isCtrl && hostResetLineN)
                    begin
                        if (mreq == smc_pkg::MREQ_NORMAL)
                            next_mode = smc_pkg::MODE_NORMAL;
                        else if (mreq == smc_pkg::MREQ_STOP)
                            next_mode = smc_pkg::MODE_STOP;
                        else if (mreq == smc_pkg::MREQ_SLEEP)
                            next_mode = smc_pkg::MODE_SLEEP;
                    end
                end
                smc_pkg::MODE_STOP:
                begin
                    if (failure)
                    begin
                        next_mode = smc_pkg::MODE_RESTART;
                        next_auto = 1'b1;
                    end
                    else if (accept && isCtrl && (mreq == smc_pkg::MREQ_NORMAL))
                    begin
                        next_mode = smc_pkg::MODE_NORMAL;
                    end
                end
                smc_pkg::MODE_SLEEP, smc_pkg::MODE_FAILSAFE:
                begin
                    if (wakeS)
                    begin
                        next_mode = smc_pkg::MODE_RESTART;
                        next_auto = 1'b1;
                    end
                end
                smc_pkg::MODE_RESTART:
                begin
                    if (resetRise)
                    begin
                        next_mode = smc_pkg::MODE_NORMAL;
                        next_auto = 1'b1;
                    end
                end
                default:
                begin
                    next_mode = smc_pkg::MODE_INIT;
                end
            endcase
        end
    end

    // mode register; only the six codes are ever loaded
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            mode <= smc_pkg::MODE_INIT;
        else
            mode <= next_mode;
    end

    // power-up origin is lost with the first soft reset
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            fromPowerUp <= 1'b1;
        else if (softReset)
            fromPowerUp <= 1'b0;
    end

    // reset output and reset delay counter
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            hostResetLineN <= 1'b0;
            rdCount <= '0;
        end
        else if (modeEntry && ((next_mode == smc_pkg::MODE_INIT)
                 || (next_mode == smc_pkg::MODE_RESTART)))
        begin
            hostResetLineN <= 1'b0;
            rdCount <= '0;
        end
        else if (resetRise)
        begin
            hostResetLineN <= 1'b1;
        end
        else if (inResetPhase)
        begin
            rdCount <= rdCount + 1'b1;
        end
    end

    // watchdog start pulse and strap pull-up follow the reset release
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            wdLongWindowStart <= 1'b0;
            devStrapPullup <= 1'b0;
        end
        else
        begin
            wdLongWindowStart <= resetRise;
            devStrapPullup <= resetRise || (hostResetLineN && !modeEntry);
        end
    end

    // test strap filter, restarted at 1 on every reset release
    smc_strap_filter #(.LEN(smc_pkg::DEVMODE_FILTER_CYC), .INIT_VAL(1'b1)) u_dev_filt
    (
        .clk(clk),
        .host_reset_line_n(host_reset_line_n),
        .load(resetRise),
        .loadVal(1'b1),
        .enable(hostResetLineN),
        .din(devStrapS),
        .q(devFilt)
    );

    // checksum strap filter runs only inside its window
    smc_strap_filter #(.LEN(smc_pkg::CHECKSUM_FILTER_CYC), .INIT_VAL(1'b1)) u_chk_filt
    (
        .clk(clk),
        .host_reset_line_n(host_reset_line_n),
        .load(!chkWindow),
        .loadVal(chkStrapS),
        .enable(chkWindow),
        .din(chkStrapS),
        .q(chkFilt)
    );

    // development mode latch; an autonomous change while monitoring vetoes it
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            devMode <= 1'b0;
        else if (devMonitor && next_auto)
            devMode <= 1'b0;
        else if (devMonitor && !devFilt && frameValid)
            devMode <= 1'b1;
    end

    // watchdog reset re-enable, only meaningful in development mode
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            wdRstReenable <= 1'b0;
        else if (accept && isCtrl && devMode)
            wdRstReenable <= frameWord[smc_pkg::WDRST_EN_BIT];
    end

    // watchdog fault reported as interrupt level, held while the fault lasts, instead of reset
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            wdFailIrq <= 1'b0;
        else
            wdFailIrq <= wdFaultS && devMode && !wdRstReenable;
    end

    // checksum setting: strap captured at reset release after power-up or restart, recovery frames in normal
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            checksumEnable <= 1'b0;
        else if (resetRise && chkWindow)
            checksumEnable <= !chkFilt;
        else if (frameValid && (mode == smc_pkg::MODE_NORMAL)
                 && (frameWord == smc_pkg::CHK_ON_FRAME))
            checksumEnable <= 1'b1;
        else if (frameValid && (mode == smc_pkg::MODE_NORMAL)
                 && (frameWord == smc_pkg::CHK_OFF_FRAME))
            checksumEnable <= 1'b0;
    end

    // spi error flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            spiFail <= 1'b0;
        else if (frameValid && !accept)
            spiFail <= 1'b1;
        else if (accept && isStatClr)
            spiFail <= 1'b0;
    end

    // feature enables written only in normal mode, held as fixed elsewhere
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
            feat <= smc_pkg::FEAT_RST;
        else if (accept && isFeat && (mode == smc_pkg::MODE_NORMAL))
            feat <= frameWord[smc_pkg::FEAT_HI:smc_pkg::FEAT_LO];
    end

    // per-mode enable table
    logic next_reg, next_sup, next_wd, next_hs, next_bd, next_cp, next_csa;
    logic next_can, next_canWake, next_wkArm, next_cSense, next_cWake;

    always_comb
    begin
        next_reg = 1'b1;
        next_sup = 1'b0;
        next_wd = 1'b0;
        next_hs = 1'b0;
        next_bd = 1'b0;
        next_cp = 1'b0;
        next_csa = 1'b0;
        next_can = 1'b0;
        next_canWake = 1'b0;
        next_wkArm = 1'b0;
        next_cSense = 1'b0;
        next_cWake = 1'b0;
        unique case (next_mode)
            smc_pkg::MODE_INIT:
            begin
                next_sup = 1'b1;
                next_wd = hostResetLineN;
                next_can = devMode;
            end
            smc_pkg::MODE_NORMAL:
            begin
                next_sup = 1'b1;
                next_wd = feat[smc_pkg::F_WD];
                next_hs = feat[smc_pkg::F_HS];
                next_bd = feat[smc_pkg::F_BD];
                next_cp = feat[smc_pkg::F_CP];
                next_csa = feat[smc_pkg::F_CSA];
                next_can = feat[smc_pkg::F_CAN];
                next_cSense = feat[smc_pkg::F_CSENSE];
                next_cWake = feat[smc_pkg::F_CWAKE];
            end
            smc_pkg::MODE_STOP:
            begin
                next_sup = 1'b1;
                next_wd = feat[smc_pkg::F_WD];
                next_hs = feat[smc_pkg::F_HS];
                next_can = feat[smc_pkg::F_CAN];
                next_wkArm = 1'b1;
                next_cSense = feat[smc_pkg::F_CSENSE];
                next_cWake = feat[smc_pkg::F_CWAKE];
            end
            smc_pkg::MODE_SLEEP:
            begin
                next_reg = 1'b0;
                next_hs = feat[smc_pkg::F_HS];
                next_canWake = feat[smc_pkg::F_CAN];
                next_wkArm = 1'b1;
                next_cSense = feat[smc_pkg::F_CSENSE];
                next_cWake = feat[smc_pkg::F_CWAKE];
            end
            smc_pkg::MODE_RESTART:
            begin
                next_canWake = feat[smc_pkg::F_CAN];
            end
            smc_pkg::MODE_FAILSAFE:
            begin
                next_reg = 1'b0;
                next_canWake = 1'b1;
                next_wkArm = 1'b1;
            end
            default:
            begin
                next_reg = 1'b1;
            end
        endcase
    end

    // registered enables follow the mode being entered
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            mainRegulatorOn <= 1'b1;
            supervisionOn <= 1'b0;
            wdRun <= 1'b0;
            highSideOn <= 1'b0;
            bridgeDriverOn <= 1'b0;
            chargePumpOn <= 1'b0;
            csaOn <= 1'b0;
            canOn <= 1'b0;
            canWakeCapable <= 1'b0;
            wakeInputsArmed <= 1'b0;
            cycSenseOn <= 1'b0;
            cycWakeOn <= 1'b0;
        end
        else
        begin
            mainRegulatorOn <= next_reg;
            supervisionOn <= next_sup;
            wdRun <= next_wd;
            highSideOn <= next_hs;
            bridgeDriverOn <= next_bd;
            chargePumpOn <= next_cp;
            csaOn <= next_csa;
            canOn <= next_can;
            canWakeCapable <= next_canWake;
            wakeInputsArmed <= next_wkArm;
            cycSenseOn <= next_cSense;
            cycWakeOn <= next_cWake;
        end
    end

    // mode code and wake-bit clear pulse on fail-safe entry
    always_ff @(posedge clk or negedge host_reset_line_n)
    begin
        if (!host_reset_line_n)
        begin
            modeState <= smc_pkg::MODE_INIT;
            wakeBitsClear <= 1'b0;
        end
        else
        begin
            modeState <= next_mode;
            wakeBitsClear <= (next_mode == smc_pkg::MODE_FAILSAFE)
                && (mode != smc_pkg::MODE_FAILSAFE);
        end
    end

endmodule

// ==== test/smc_mode_controller_assertions.sv ====
// checker for the mode controller ports
// assumes one clock and host_reset_line_n async active low
`timescale 1ns/100ps
module smc_mode_controller_checker
(
    // watched ports
    input wire logic clk, host_reset_line_n, thermalShutdown, frameValid,
    input wire logic [31:0] frameWord,
    input wire logic [2:0] modeState,
    input wire logic hostResetLineN, devMode, checksumEnable, spiFail, wdFailIrq,
    input wire logic wdLongWindowStart, wakeBitsClear, mainRegulatorOn, supervisionOn,
    input wire logic wdRun, highSideOn, bridgeDriverOn, chargePumpOn, csaOn, canOn,
    input wire logic canWakeCapable, cycSenseOn, cycWakeOn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!host_reset_line_n);
    // feature write, one of the kinds stop must refuse
    logic featWr;
    assign featWr = frameValid && frameWord[31] && frameWord[30:24] == smc_pkg::ADDR_FEATURE;
    a_mode_legal: assert property (modeState <= 3'h5) else $error("bad mode code");
    a_restart_reset: assert property (modeState == 3'h4 |-> !hostResetLineN)
        else $error("reset line high in restart");
    a_thermal_failsafe: assert property ($rose(thermalShutdown)
        |-> ##[1:4] modeState == 3'h5) else $error("no fail-safe after thermal");
    a_dev_irq: assert property (wdFailIrq |-> devMode) else $error("irq without dev");
    a_long_window: assert property ($rose(hostResetLineN)
        |-> ##[0:1] wdLongWindowStart) else $error("no long window start");
    a_init_off: assert property (modeState == 3'h0
        |-> mainRegulatorOn && !(highSideOn || bridgeDriverOn || chargePumpOn || csaOn ||
        cycSenseOn || cycWakeOn)) else $error("init enables wrong");
    a_init_can: assert property (modeState == 3'h0 && !devMode |-> !canOn)
        else $error("can on in init");
    a_normal_sup: assert property (modeState == 3'h1
        |-> mainRegulatorOn && supervisionOn) else $error("normal supply off");
    a_chk_on: assert property (frameValid && frameWord == smc_pkg::CHK_ON_FRAME &&
        modeState == 3'h1 |=> checksumEnable) else $error("checksum not on");
    a_chk_off: assert property (frameValid && frameWord == smc_pkg::CHK_OFF_FRAME &&
        modeState == 3'h1 |=> !checksumEnable) else $error("checksum not off");
    a_stop_fail: assert property (featWr && modeState == 3'h2 |=> spiFail)
        else $error("stop write not flagged");
    a_failsafe_state: assert property (modeState == 3'h5
        |-> !mainRegulatorOn && !wdRun && !highSideOn && canWakeCapable)
        else $error("fail-safe enables wrong");
    a_wake_clear: assert property ($rose(modeState == 3'h5)
        |-> ##[0:1] wakeBitsClear) else $error("wake bits not cleared");
    c_failsafe: cover property (modeState == 3'h5);
    c_stop_write: cover property (featWr && modeState == 3'h2);
    c_release: cover property ($rose(hostResetLineN));
endmodule
bind smc_mode_controller smc_mode_controller_checker u_chk (.*);

// ==== test/smc_host_model.sv ====
// host side: sends whole 32-bit frames, one per call
// assumes the bench calls send only once the reset line is high
`timescale 1ns/100ps
module smc_host_model
(
    // clock
    input wire logic clk,
    // frame port
    output logic frameValid,
    output logic [31:0] frameWord
);
    initial
    begin
        frameValid = 1'b0;
        frameWord = 32'h0;
    end
    // released word is inverted so a stale frame never looks valid
    task automatic send(input logic [31:0] w);
        @(posedge clk);
        #1 frameValid = 1'b1;
        frameWord = w;
        @(posedge clk);
        #1 frameValid = 1'b0;
        frameWord = ~w;
    endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the mode controller
// assumes the host model drives frames and the checker is bound
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
    logic clk = 0, host_reset_line_n = 0, porFlag = 1, regAboveReset = 1, wakeEvent = 0, wdFault = 0;
    logic regUndervoltage = 0, thermalShutdown = 0, devStrapPin = 1;
    logic firstPwmChecksumStrapPin = 0, frameValid, hostResetLineN, devStrapPullup, devMode;
    logic checksumEnable, spiFail, wdFailIrq, wdLongWindowStart, wakeBitsClear, mainRegulatorOn;
    logic supervisionOn, wdRun, highSideOn, bridgeDriverOn, chargePumpOn, csaOn, canOn;
    logic canWakeCapable, wakeInputsArmed, cycSenseOn, cycWakeOn;
    logic [31:0] frameWord, w;
    logic [2:0] modeState;
    logic [7:0] feat;
    int miscompares = 0, n_tests = 0, expMode;
    always #2.5 clk = ~clk;
    smc_host_model host (.clk(clk), .frameValid(frameValid), .frameWord(frameWord));
    smc_mode_controller DUT (.*);
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on the controller's mode; a hang ends the run
    task automatic wait_mode();
        int i;
        for (i = 0; i < 3000 && modeState !== 3'(expMode); i++)
            step(1);
        `CHK("mode", 3'(expMode), modeState);
        if (i == 3000) final_report();
    endtask
    // reset held 5 cycles, then a bounded wait for the reset line to rise
    task automatic reset_run();
        host_reset_line_n = 0;
        step(5);
        `CHK("reset line", 1'b0, hostResetLineN);
        host_reset_line_n = 1;
        for (int i = 0; i < 3000 && hostResetLineN !== 1'b1; i++) step(1);
        `CHK("release", 1'b1, hostResetLineN);
        if (hostResetLineN !== 1'b1) final_report();
    endtask
    // mode request frame with random filler bits, dev reset bit kept low
    task automatic request(input logic [2:0] code, input int m);
        w = $urandom;
        w[31:24] = {1'b1, smc_pkg::ADDR_MODE_CTRL};
        w[11:8] = {1'b0, code};
        host.send(w);
        expMode = m;
        step(2);
        wait_mode();
    endtask
    initial
    begin
        void'($urandom(32'hecb8));
        reset_run();
        step(2);
        `CHK("strap crc", 1'b1, checksumEnable);
        `CHK("pullup", 1'b1, devStrapPullup);
        expMode = 0;
        wait_mode();
        $display("test power-up done");
        request(smc_pkg::MREQ_NORMAL, 1);
        `CHK("dev mode", 1'b0, devMode);
        feat = 8'($urandom);
        host.send({1'b1, smc_pkg::ADDR_FEATURE, 8'($urandom), feat, 8'($urandom)});
        step(2);
        `CHK("features", feat, {wdRun, cycWakeOn, cycSenseOn, canOn, csaOn, chargePumpOn,
            bridgeDriverOn, highSideOn});
        host.send(smc_pkg::CHK_OFF_FRAME);
        step(2);
        `CHK("crc off", 1'b0, checksumEnable);
        host.send(smc_pkg::CHK_ON_FRAME);
        step(2);
        `CHK("crc on", 1'b1, checksumEnable);
        $display("test normal done");
        request(smc_pkg::MREQ_STOP, 2);
        host.send({1'b1, smc_pkg::ADDR_FEATURE, 24'hFFFF00});
        step(2);
        `CHK("stop fail", 1'b1, spiFail);
        host.send({1'b1, smc_pkg::ADDR_SPI_STAT, 24'h000000});
        step(2);
        `CHK("stop clear", 1'b0, spiFail);
        request(smc_pkg::MREQ_NORMAL, 1);
        $display("test stop done");
        thermalShutdown = 1;
        expMode = 5;
        wait_mode();
        `CHK("fs reg", 1'b0, mainRegulatorOn);
        `CHK("fs can", 1'b1, canWakeCapable);
        `CHK("fs wake arm", 1'b1, wakeInputsArmed);
        thermalShutdown = 0;
        wakeEvent = 1;
        expMode = 4;
        wait_mode();
        `CHK("restart line", 1'b0, hostResetLineN);
        wakeEvent = 0;
        expMode = 1;
        wait_mode();
        $display("test fail-safe done");
        // pulled-down test strap across a mid-run reset, then any frame latches dev mode
        devStrapPin = 0;
        reset_run();
        step(250);
        w = $urandom;
        w[31] = 1'b0;
        host.send(w);
        step(2);
        `CHK("dev latch", 1'b1, devMode);
        `CHK("dev can", 1'b1, canOn);
        wdFault = 1;
        step(4);
        `CHK("dev irq", 1'b1, wdFailIrq);
        expMode = 0;
        wait_mode();
        wdFault = 0;
        $display("test development mode done");
        final_report();
    end
endmodule
